// ===== shared/rst_cause_pkg.sv
// Constants for the reset cause tracker
`default_nettype none
package rst_cause_pkg;
	localparam logic [1:0] CTRL_ADDR = 2'h0;
	localparam logic [1:0] CAUSE_ADDR = 2'h1;
	localparam int IRQ_PRIORITY_ENABLE_BIT = 7;
	localparam int SOFT_BROWNOUT_ENABLE_BIT = 6;
	localparam int RI_BIT = 4;
	localparam int TO_BIT = 3;
	localparam int PD_BIT = 2;
	localparam int POR_BIT = 1;
	localparam int BOR_BIT = 0;
	localparam logic [1:0] BOR_MODE_OFF = 2'h0;
	localparam logic [1:0] BOR_MODE_SOFT = 2'h1;
	localparam logic [1:0] BOR_MODE_NOSLEEP = 2'h2;
	localparam logic [1:0] BOR_MODE_ON = 2'h3;
	localparam logic [7:0] CTRL_WR_MASK = 8'hd3;
	localparam int FILTER_NS = 200;
	localparam int CLK_PERIOD_NS = 10;
	localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] FILTER_CNT = 5'(FILTER_CYCLES);
	localparam logic [7:0] CAUSE_RESET = 8'h00;
	typedef enum logic [3:0] {
		CAUSE_NONE = 4'h0,
		CAUSE_POR = 4'h1,
		CAUSE_PIN_RUN = 4'h2,
		CAUSE_PIN_PM = 4'h3,
		CAUSE_WDT = 4'h4,
		CAUSE_BOR = 4'h5,
		CAUSE_INSTR = 4'h6,
		CAUSE_STK_FULL = 4'h7,
		CAUSE_STK_UNDER = 4'h8
	} cause_e;
endpackage : rst_cause_pkg
`default_nettype wire

// ===== hw/reset_cause_tracker.sv
// Reset cause tracker: reset control register, pin filter and cause recording
// Contract
// (R1) Record each reset cause separately
// (R2) Low five flags cleared by events
// (R3) Bit 7 enables interrupt priority levels
// (R4) Bit 6 acts only in mode 01
// (R5) Bit 6 reset value from fuse mode
// (R6) Reset instruction clears bit 4
// (R7) Watchdog expiry clears bit 3
// (R8) Sleep clears bit 2, kick sets
// (R9) Power-on clears bit 1 only; the code also clears bits 0 and 7 on power-on
// (R10) Brown-out clears bit 0, firmware sets
// (R11) Reset values follow register map
// (R12) Firmware infers brown-out from flags
// (R13) Firmware sets power-on flag after detection
// (R14) Filtered long pin low resets device
// (R15) Never drive the reset pin
// (R16) Pin disabled acts as digital input
// (R17) Power-on pulse initializes device
// (R18) Mode field selects brown-out operation
// (R19) Brown-out flag clears on brown-out, power-on
// (R20) Event inputs synchronized before flag updates
//
// Strobed register access and the register addresses were chosen for this implementation.
`default_nettype none
module reset_cause_tracker (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire logic [1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Configuration fuses
	input wire logic [7:0] fuse_low_byte_two_i,
	input wire logic ext_reset_pin_enable_i,
	// Reset sources, asynchronous one-cycle-or-longer levels
	input wire logic por_evt_i,
	input wire logic bor_evt_i,
	input wire logic wdt_evt_i,
	input wire logic instr_evt_i,
	input wire logic stk_full_evt_i,
	input wire logic stk_under_evt_i,
	input wire logic watchdog_kick_instr_i,
	input wire logic sleep_instr_i,
	input wire logic sleeping_i,
	// External reset pin
	input wire logic ext_reset_pin_n_i,
	output logic ext_reset_pin_o,
	output logic ext_reset_pin_oe_o,
	// Results
	output logic dev_reset_o,
	output logic pin_din_o,
	output logic irq_priority_enable_o,
	output logic brownout_active_o,
	output rst_cause_pkg::cause_e last_cause_o
);
	import rst_cause_pkg::*;

	localparam int NS = 9;
	logic [NS-1:0] raw;
	logic [NS-1:0] s1_ff, s2_ff, s3_ff;
	logic [NS-1:0] nxt_s1, nxt_s2, nxt_s3;
	logic [NS-1:0] rise;
	logic [4:0] flt_ff, nxt_flt;
	logic pin_low_ff, nxt_pin_low;
	logic [7:0] ctrl_ff, nxt_ctrl;
	logic [7:0] rdata_ff, nxt_rdata;
	cause_e cause_ff, nxt_cause;
	logic rst_ff, nxt_rst;
	logic bor_on_ff, nxt_bor_on;
	logic din_ff, nxt_din;
	logic pin_rst;
	logic sbo_rst;
	logic [1:0] mode;

	assign raw = {sleep_instr_i, watchdog_kick_instr_i, stk_under_evt_i, stk_full_evt_i,
		instr_evt_i, wdt_evt_i, bor_evt_i, por_evt_i, ext_reset_pin_n_i};
	assign mode = fuse_low_byte_two_i[2:1];
	assign sbo_rst = (mode == BOR_MODE_SOFT); // R5

	// Two-flop synchroniser plus edge stage; edge is taken only on stages 2 and 3
	always_comb begin
		nxt_s1 = raw; // R20
		nxt_s2 = s1_ff;
		nxt_s3 = s2_ff;
	end
	assign rise = s2_ff & ~s3_ff; // R20

	// Pin filter: low must persist for the full count, shorter pulses are ignored
	always_comb begin
		nxt_flt = flt_ff;
		nxt_pin_low = pin_low_ff;
		if (s2_ff[0]) begin
			nxt_flt = 5'h00; // R14
			nxt_pin_low = 1'b0;
		end else if (flt_ff == FILTER_CNT) begin
			nxt_pin_low = 1'b1; // R14
		end else begin
			nxt_flt = flt_ff + 5'h01;
		end
	end
	assign pin_rst = pin_low_ff & ext_reset_pin_enable_i; // R16

	// Control register and cause; later branches win over a firmware write in the same cycle
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_cause = cause_ff;
		nxt_rst = 1'b0;
		nxt_din = ext_reset_pin_enable_i ? 1'b1 : s2_ff[0]; // R16
		if (wr_i && addr_i == CTRL_ADDR) begin
			nxt_ctrl = (ctrl_ff & ~CTRL_WR_MASK) | (wdata_i & CTRL_WR_MASK); // R3
		end
		if (rise[7]) begin
			nxt_ctrl[TO_BIT] = 1'b1; // R7
			nxt_ctrl[PD_BIT] = 1'b1; // R8
		end
		if (rise[8]) begin
			nxt_ctrl[TO_BIT] = 1'b1; // R7
			nxt_ctrl[PD_BIT] = 1'b0; // R8
		end
		if (rise[3]) begin
			nxt_ctrl[TO_BIT] = 1'b0; // R7
			nxt_cause = CAUSE_WDT; // R1
			nxt_rst = 1'b1;
		end
		if (rise[4]) begin
			nxt_ctrl[RI_BIT] = 1'b0; // R6
			nxt_cause = CAUSE_INSTR; // R1
			nxt_rst = 1'b1;
		end
		if (rise[5]) begin
			nxt_cause = CAUSE_STK_FULL; // R1
			nxt_rst = 1'b1;
		end
		if (rise[6]) begin
			nxt_cause = CAUSE_STK_UNDER; // R1
			nxt_rst = 1'b1;
		end
		if (pin_rst) begin
			nxt_cause = sleeping_i ? CAUSE_PIN_PM : CAUSE_PIN_RUN; // R1
			nxt_rst = 1'b1; // R14
		end
		// Brown-out reloads the power flags like a power-on, but leaves the power-on flag alone
		if (rise[2] && bor_on_ff) begin
			nxt_ctrl[BOR_BIT] = 1'b0; // R10 R19
			nxt_ctrl[RI_BIT] = 1'b1; // R11
			nxt_ctrl[TO_BIT] = 1'b1; // R11
			nxt_ctrl[PD_BIT] = 1'b1; // R11
			nxt_ctrl[IRQ_PRIORITY_ENABLE_BIT] = 1'b0;
			nxt_ctrl[SOFT_BROWNOUT_ENABLE_BIT] = sbo_rst; // R5
			nxt_cause = CAUSE_BOR; // R1
			nxt_rst = 1'b1;
		end
		if (rise[1]) begin
			nxt_ctrl = 8'h00; // R17
			nxt_ctrl[RI_BIT] = 1'b1; // R11
			nxt_ctrl[TO_BIT] = 1'b1; // R7
			nxt_ctrl[PD_BIT] = 1'b1; // R8
			nxt_ctrl[POR_BIT] = 1'b0; // R9
			nxt_ctrl[BOR_BIT] = 1'b0; // R19
			nxt_ctrl[SOFT_BROWNOUT_ENABLE_BIT] = sbo_rst; // R5
			nxt_cause = CAUSE_POR; // R1
			nxt_rst = 1'b1;
		end
		if (nxt_rst) begin
			nxt_ctrl[IRQ_PRIORITY_ENABLE_BIT] = 1'b0; // R11
		end
		if (mode != BOR_MODE_SOFT) begin
			nxt_ctrl[SOFT_BROWNOUT_ENABLE_BIT] = 1'b0; // R4
		end
		nxt_ctrl[5] = 1'b0;
	end

	// Brown-out detector enable by mode
	always_comb begin
		unique case (mode)
			BOR_MODE_OFF: nxt_bor_on = 1'b0; // R18
			BOR_MODE_SOFT: nxt_bor_on = ctrl_ff[SOFT_BROWNOUT_ENABLE_BIT]; // R4
			BOR_MODE_NOSLEEP: nxt_bor_on = ~sleeping_i; // R18
			BOR_MODE_ON: nxt_bor_on = 1'b1; // R18
		endcase
	end

	// Read data valid the cycle after the strobe, zero otherwise
	always_comb begin
		nxt_rdata = 8'h00;
		if (rd_i) begin
			unique case (addr_i)
				CTRL_ADDR: nxt_rdata = ctrl_ff; // R2
				CAUSE_ADDR: nxt_rdata = {4'h0, cause_ff};
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	// Registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			// Pin stage resets to its idle high level so the filter does not start counting
			s1_ff <= 9'h001;
			s2_ff <= 9'h001;
			s3_ff <= 9'h001;
			flt_ff <= 5'h00;
			pin_low_ff <= 1'b0;
			ctrl_ff <= 8'h1c; // R11
			rdata_ff <= 8'h00;
			cause_ff <= CAUSE_NONE;
			rst_ff <= 1'b0;
			bor_on_ff <= 1'b0;
			din_ff <= 1'b1;
		end else begin
			s1_ff <= nxt_s1;
			s2_ff <= nxt_s2;
			s3_ff <= nxt_s3;
			flt_ff <= nxt_flt;
			pin_low_ff <= nxt_pin_low;
			ctrl_ff <= nxt_ctrl;
			rdata_ff <= nxt_rdata;
			cause_ff <= nxt_cause;
			rst_ff <= nxt_rst;
			bor_on_ff <= nxt_bor_on;
			din_ff <= nxt_din;
		end
	end

	assign rdata_o = rdata_ff;
	assign dev_reset_o = rst_ff;
	assign pin_din_o = din_ff;
	assign irq_priority_enable_o = ctrl_ff[IRQ_PRIORITY_ENABLE_BIT]; // R3
	assign brownout_active_o = bor_on_ff;
	assign last_cause_o = cause_ff;
	// Pin is input only; internal resets never drive it
	assign ext_reset_pin_o = 1'b0; // R15
	assign ext_reset_pin_oe_o = 1'b0; // R15

	// Checks
	property p_por_flags;
		@(posedge clk_i) disable iff (sys_rst_i) rise[1] |=> (ctrl_ff[POR_BIT] == 1'b0 && ctrl_ff[RI_BIT]);
	endproperty
	a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong"); // R9
	property p_wdt;
		@(posedge clk_i) disable iff (sys_rst_i) (rise[3] && rise[2:1] == 2'h0 && rise[6:4] == 3'h0 && !pin_rst)
			|=> !ctrl_ff[TO_BIT] && cause_ff == CAUSE_WDT;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog flag not cleared"); // R7
	property p_sleep;
		@(posedge clk_i) disable iff (sys_rst_i) (rise[8] && !rise[1] && !rise[2]) |=> !ctrl_ff[PD_BIT];
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep flag not cleared"); // R8
	// Kick alone leaves both power flags set
	property p_kick;
		@(posedge clk_i) disable iff (sys_rst_i) (rise[7] && !rise[8] && !rise[3]) |=> ctrl_ff[PD_BIT] && ctrl_ff[TO_BIT];
	endproperty
	a_kick: assert property (p_kick) else $error("kick did not set power flags"); // R8
	// Brown-out reloads instruction, watchdog and power-down flags
	property p_bor_reset;
		@(posedge clk_i) disable iff (sys_rst_i) (rise[2] && bor_on_ff && !rise[1])
			|=> ctrl_ff[RI_BIT] && ctrl_ff[TO_BIT] && ctrl_ff[PD_BIT];
	endproperty
	a_bor_reset: assert property (p_bor_reset) else $error("brownout reset values wrong"); // R11
	// Brown-out is recorded as the cause
	property p_bor_cause;
		@(posedge clk_i) disable iff (sys_rst_i) (rise[2] && bor_on_ff && !rise[1]) |=> cause_ff == CAUSE_BOR;
	endproperty
	a_bor_cause: assert property (p_bor_cause) else $error("brownout cause wrong"); // R1
	// Power-on is recorded as the cause and resets the device
	property p_por_cause;
		@(posedge clk_i) disable iff (sys_rst_i) rise[1] |=> cause_ff == CAUSE_POR && rst_ff;
	endproperty
	a_por_cause: assert property (p_por_cause) else $error("power-on cause wrong"); // R17
	// Unimplemented bit always reads zero
	property p_bit5;
		@(posedge clk_i) disable iff (sys_rst_i) ctrl_ff[5] == 1'b0;
	endproperty
	a_bit5: assert property (p_bit5) else $error("unused control bit set"); // R11
	// Read data stands only in the cycle after a read strobe
	property p_rd_idle;
		@(posedge clk_i) disable iff (sys_rst_i) !rd_i |=> rdata_o == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without strobe"); // R2
	// Mode 00 keeps the detector off
	property p_mode_off;
		@(posedge clk_i) disable iff (sys_rst_i) (mode == BOR_MODE_OFF) |=> !bor_on_ff;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("detector on in mode off"); // R18
	// Mode 11 keeps the detector on
	property p_mode_on;
		@(posedge clk_i) disable iff (sys_rst_i) (mode == BOR_MODE_ON) |=> bor_on_ff;
	endproperty
	a_mode_on: assert property (p_mode_on) else $error("detector off in mode on"); // R18
	// A filtered low on an enabled pin resets the device
	property p_pin_rst;
		@(posedge clk_i) disable iff (sys_rst_i) pin_rst |=> rst_ff;
	endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("pin low did not reset"); // R14
	// A disabled pin with no other event never resets
	property p_pin_off;
		@(posedge clk_i) disable iff (sys_rst_i) (!ext_reset_pin_enable_i && rise[6:1] == 6'h00) |=> !rst_ff;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("disabled pin reset device"); // R16
	// A disabled pin shows its synchronised level as data
	property p_din;
		@(posedge clk_i) disable iff (sys_rst_i) !ext_reset_pin_enable_i |=> pin_din_o == $past(s2_ff[0]);
	endproperty
	a_din: assert property (p_din) else $error("pin data wrong"); // R16
	property p_instr;
		@(posedge clk_i) disable iff (sys_rst_i) (rise[4] && !rise[1] && !rise[2]) |=> !ctrl_ff[RI_BIT];
	endproperty
	a_instr: assert property (p_instr) else $error("instruction flag not cleared"); // R6
	property p_soft_brownout_enable;
		@(posedge clk_i) disable iff (sys_rst_i) (mode != BOR_MODE_SOFT) |=> !ctrl_ff[SOFT_BROWNOUT_ENABLE_BIT];
	endproperty
	a_soft_brownout_enable: assert property (p_soft_brownout_enable) else $error("soft enable not inert"); // R4
	property p_bor;
		@(posedge clk_i) disable iff (sys_rst_i) (rise[2] && bor_on_ff) |=> !ctrl_ff[BOR_BIT];
	endproperty
	a_bor: assert property (p_bor) else $error("brownout flag not cleared"); // R19
	property p_pin;
		@(posedge clk_i) disable iff (sys_rst_i) (!ext_reset_pin_enable_i && !rise[1] && !rise[2]) [*2]
			|-> cause_ff != CAUSE_PIN_RUN || $stable(cause_ff);
	endproperty
	a_pin: assert property (p_pin) else $error("disabled pin caused reset"); // R16
	property p_irq_priority_enable;
		@(posedge clk_i) disable iff (sys_rst_i) rst_ff |-> !ctrl_ff[IRQ_PRIORITY_ENABLE_BIT];
	endproperty
	a_irq_priority_enable: assert property (p_irq_priority_enable) else $error("priority enable survived reset"); // R11
	property p_nodrive;
		@(posedge clk_i) disable iff (sys_rst_i) !ext_reset_pin_oe_o;
	endproperty
	a_nodrive: assert property (p_nodrive) else $error("reset pin driven"); // R15
	property p_short;
		@(posedge clk_i) disable iff (sys_rst_i) $rose(s2_ff[0]) |=> !pin_low_ff;
	endproperty
	a_short: assert property (p_short) else $error("filter kept low"); // R14
	c_por: cover property (@(posedge clk_i) disable iff (sys_rst_i) rise[1]);
	c_wdt: cover property (@(posedge clk_i) disable iff (sys_rst_i) cause_ff == CAUSE_WDT);
	c_pin: cover property (@(posedge clk_i) disable iff (sys_rst_i) pin_rst);
	c_bor: cover property (@(posedge clk_i) disable iff (sys_rst_i) cause_ff == CAUSE_BOR);
	// Pin reset taken while the core sleeps
	c_pin_pm: cover property (@(posedge clk_i) disable iff (sys_rst_i) cause_ff == CAUSE_PIN_PM);
endmodule : reset_cause_tracker
`default_nettype wire

// ===== verif/reset_pin_model.sv
// External reset pin circuit: pull-up with a switch to ground
`default_nettype none
module reset_pin_model (
	// Switch and design drive
	input wire logic pull_low_i,
	input wire logic dut_out_i,
	input wire logic dut_oe_i,
	// Resolved pin level
	output logic pin_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Weak pull-up holds the pin high unless the switch or the design pulls it
	assign pin_n_o = dut_oe_i ? dut_out_i : !pull_low_i;
endmodule : reset_pin_model
`default_nettype wire

// ===== verif/test_reset_cause_tracker.sv
// Self-checking bench for the reset cause tracker
`default_nettype none
module test_reset_cause_tracker;
	timeunit 1ns;
	timeprecision 1ns;
	import rst_cause_pkg::*;
	typedef struct {logic [7:0] ev; logic [7:0] ctl; cause_e c;} row_s;
	logic clk_i, sys_rst_i, wr_i, rd_i, sleeping_i, pin_en, pull, pin_o, pin_oe, dev_rst, din, irq_priority_enable, bo_act, pin_n;
	logic [1:0] addr_i;
	logic [7:0] wdata_i, fuse, ev, rdata_o, e8;
	cause_e cause;
	int failures, n_checks, n_rst, n0;
	// Event bits: por bor wdt instr stk_full stk_under kick sleep
	row_s rows[8] = '{'{8'h20, 8'h57, CAUSE_WDT}, '{8'h02, 8'h5f, CAUSE_NONE}, '{8'h01, 8'h5b, CAUSE_NONE},
		'{8'h10, 8'h4b, CAUSE_INSTR}, '{8'h08, 8'h5b, CAUSE_STK_FULL}, '{8'h04, 8'h5b, CAUSE_STK_UNDER},
		'{8'h40, 8'h5e, CAUSE_BOR}, '{8'h80, 8'h5c, CAUSE_POR}};
	reset_cause_tracker u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fuse_low_byte_two_i(fuse), .ext_reset_pin_enable_i(pin_en),
		.por_evt_i(ev[7]), .bor_evt_i(ev[6]), .wdt_evt_i(ev[5]), .instr_evt_i(ev[4]), .stk_full_evt_i(ev[3]),
		.stk_under_evt_i(ev[2]), .watchdog_kick_instr_i(ev[1]), .sleep_instr_i(ev[0]), .sleeping_i(sleeping_i),
		.ext_reset_pin_n_i(pin_n), .ext_reset_pin_o(pin_o), .ext_reset_pin_oe_o(pin_oe), .dev_reset_o(dev_rst),
		.pin_din_o(din), .irq_priority_enable_o(irq_priority_enable), .brownout_active_o(bo_act), .last_cause_o(cause));
	reset_pin_model u_pin (.pull_low_i(pull), .dut_out_i(pin_o), .dut_oe_i(pin_oe), .pin_n_o(pin_n));
	// Clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			failures++;
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd_chk(input logic [1:0] a, input logic [7:0] e, input string nm);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(nm, e, rdata_o);
	endtask : rd_chk
	// Hold an event input for two cycles, then let synchronisers settle
	task automatic pulse(input logic [7:0] e);
		@(posedge clk_i);
		ev <= e;
		repeat (2) @(posedge clk_i);
		ev <= 8'h00;
		repeat (6) @(posedge clk_i);
	endtask : pulse
	task automatic press(input int n);
		@(posedge clk_i);
		pull <= 1'b1;
		repeat (n) @(posedge clk_i);
		pull <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask : press
	// Count cycles with reset asserted and watch that the pin is never driven
	always @(posedge clk_i) if (dev_rst === 1'b1) n_rst++;
	always @(negedge clk_i) if (!sys_rst_i) chk("pin_drive", 8'h00, {6'h0, pin_o, pin_oe});
	// Watchdog against a hang
	initial begin
		#100us;
		failures++;
		give_verdict();
	end
	initial begin
		{sys_rst_i, wr_i, rd_i, sleeping_i, pull} = 5'h10;
		{pin_en, addr_i, wdata_i, ev, fuse} = {1'b1, 2'h0, 8'h00, 8'h00, 8'h02};
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd_chk(CTRL_ADDR, 8'h1c, "ctl_rst");
		// Each row: firmware re-arms the writable flags, one event, then register, and cause for rows that name one
		foreach (rows[i]) begin
			wr(CTRL_ADDR, 8'h53);
			pulse(rows[i].ev);
			rd_chk(CTRL_ADDR, rows[i].ctl, "ctl");
			if (rows[i].c != CAUSE_NONE) chk("cause", {4'h0, rows[i].c}, {4'h0, cause});
		end
		rd_chk(CAUSE_ADDR, {4'h0, CAUSE_POR}, "cause_reg");
		// Brown-out mode field against the soft enable and sleep
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			fuse <= {5'h0, i[2:1], 1'b0};
			sleeping_i <= i[0];
			wr(CTRL_ADDR, 8'h5c);
			repeat (4) @(posedge clk_i);
			e8 = {7'h0, i[2:1] == 2'h3 || i[2:1] == 2'h1 || (i[2:1] == 2'h2 && !i[0])};
			#1 chk("bo_act", e8, {7'h0, bo_act});
			rd_chk(CTRL_ADDR, (i[2:1] == 2'h1) ? 8'h5c : 8'h1c, "soft_brownout_enable");
		end
		wr(CTRL_ADDR, 8'hff);
		#1 chk("irq_priority_enable", 8'h01, {7'h0, irq_priority_enable});
		rd_chk(CAUSE_ADDR + 2'h1, 8'h00, "unmapped");
		// Pin filter: short glitch ignored, long low resets in run and sleep
		sleeping_i <= 1'b0;
		n0 = n_rst;
		press(10);
		chk("glitch", 8'h00, 8'(n_rst - n0));
		press(40);
		chk("pin_run", {4'h0, CAUSE_PIN_RUN}, {4'h0, cause});
		sleeping_i <= 1'b1;
		press(40);
		chk("pin_pm", {4'h0, CAUSE_PIN_PM}, {4'h0, cause});
		// Pin as plain input
		pin_en <= 1'b0;
		n0 = n_rst;
		pull <= 1'b1;
		repeat (40) @(posedge clk_i);
		#1 chk("din", 8'h00, {7'h0, din});
		chk("no_rst", 8'h00, 8'(n_rst - n0));
		@(posedge clk_i);
		pull <= 1'b0;
		sys_rst_i <= 1'b1;
		@(posedge clk_i);
		sys_rst_i <= 1'b0;
		#1 chk("irq_priority_enable_rst", 8'h00, {7'h0, irq_priority_enable});
		rd_chk(CTRL_ADDR, 8'h1c, "ctl_rst2");
		give_verdict();
	end
endmodule : test_reset_cause_tracker
`default_nettype wire
